/* rtl/pll_ctrl_defs.svh */
// constants for the pll mode and reset controller: offsets, fields, resets
// assumes a 20 MHz pclk and byte addresses on an 8-bit apb address
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH
`define NUM_CHAN 4
`define NUM_IN 4
`define NVM_WORDS 8
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_XPOINT 8'h08
`define CHAN_AREA 3'b001
`define CTRL_HARD 0
`define CTRL_SOFT_ALL 1
`define CTRL_STORE 2
`define CTRL_SOFT_CH_LSB 4
`define CFG_SEL_LSB 0
`define CFG_AUTO 2
`define CFG_FL_EN 3
`define CFG_LBW_LSB 4
`define CFG_FLBW_LSB 8
`define PLAN_PDIV_LSB 0
`define PLAN_MULT_LSB 8
`define PLAN_RDIV_LSB 24
`define CFG_RST 32'h0000_0c84
`define PLAN_RST 32'h0401_0001
`define XPOINT_RST 8'h00
`define LBW_MIN_CODE 4'h0
`define LBW_MAX_CODE 4'hf
`define FLBW_MIN_CODE 4'h8
`define LOAD_LAST 3'h7
`endif

/* rtl/pll_ctrl_pkg.sv */
// types shared by the pll mode and reset controller
// assumes pll_ctrl_defs.svh supplies every number except the one-hot state codes set here
package pll_ctrl_pkg;
   typedef enum logic [3:0] {
      MODE_FREERUN = 4'b0001,
      MODE_ACQUIRE = 4'b0010,
      MODE_LOCKED = 4'b0100,
      MODE_HOLDOVER = 4'b1000
   } mode_t;
   typedef enum logic [1:0] {
      INIT_LOAD = 2'b01,
      INIT_RUN = 2'b10
   } init_t;
endpackage : pll_ctrl_pkg

/* rtl/pll_mode_reset_control.sv */
// pll channel mode sequencing, power-up load and reset handling
// assumes an apb master on pclk; pins and loop status arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_defs.svh"
module pll_mode_reset_control
   import pll_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reset_pin_active_low,
   input wire logic [3:0] in_valid,
   input wire logic [3:0] lock_done,
   output logic init_done,
   output logic [3:0] clk_out_enable,
   output logic [7:0] clk_out_chan,
   output logic [15:0] chan_mode,
   output logic [7:0] chan_input,
   output logic [15:0] chan_bw,
   output logic [127:0] chan_plan
);

   ////////////////////////////////////////////////////////////////////////
   logic rpin_s1_r, rpin_s2_r, pready_r, pslverr_r;
   logic [3:0] valid_s1_r, valid_s2_r, lock_s1_r, lock_s2_r;
   logic [3:0] out_en_r, soft_req;
   init_t init_r;
   logic [2:0] ld_cnt_r;
   logic [31:0] prdata_r, rd_nxt;
   logic [31:0] cfg_p_r [`NUM_CHAN], plan_p_r [`NUM_CHAN];
   logic [31:0] cfg_a_r [`NUM_CHAN], plan_a_r [`NUM_CHAN];
   logic [31:0] nvm_r [`NVM_WORDS];
   logic [7:0] xpoint_r;
   mode_t mode_r [`NUM_CHAN], mode_nxt [`NUM_CHAN];
   logic [1:0] sel_r [`NUM_CHAN], sel_nxt [`NUM_CHAN];
   logic [3:0] bw_r [`NUM_CHAN], bw_nxt [`NUM_CHAN];
   logic run, done, wr, hard_req, wr_ctrl, store_req;
   ////////////////////////////////////////////////////////////////////////
   // helpers
   // lowest-numbered valid input, with a flag saying one exists
   function automatic logic [2:0] pick_valid(input logic [3:0] v);
      logic [2:0] r;
      r = 3'b000;
      for (int i = `NUM_IN - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction : pick_valid
   function automatic logic addr_hit(input logic [7:0] a);
      return (a[1:0] == 2'b00) && ((a == `ADDR_CTRL) ||
             (a == `ADDR_STATUS) || (a == `ADDR_XPOINT) ||
             (a[7:5] == `CHAN_AREA));
   endfunction : addr_hit
   ////////////////////////////////////////////////////////////////////////
   // synchronisers for the pin and the analog status lines
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpin_s1_r <= 1'b1;
         rpin_s2_r <= 1'b1;
         valid_s1_r <= 4'h0;
         valid_s2_r <= 4'h0;
         lock_s1_r <= 4'h0;
         lock_s2_r <= 4'h0;
      end else begin
         rpin_s1_r <= reset_pin_active_low;
         rpin_s2_r <= rpin_s1_r;
         valid_s1_r <= in_valid;
         valid_s2_r <= valid_s1_r;
         lock_s1_r <= lock_done;
         lock_s2_r <= lock_s1_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // apb decode
   assign run = (init_r == INIT_RUN);
   assign done = psel && penable && pready_r;
   assign wr = done && pwrite && (paddr[1:0] == 2'b00);
   assign wr_ctrl = wr && (paddr == `ADDR_CTRL);
   // a held pin keeps the load sequence restarting
   assign hard_req = !rpin_s2_r || (wr_ctrl && pwdata[`CTRL_HARD]);
   assign store_req = wr_ctrl && pwdata[`CTRL_STORE];
   always_comb begin
      soft_req = 4'h0;
      if (wr_ctrl) begin
         soft_req = pwdata[`CTRL_SOFT_CH_LSB +: 4];
         if (pwdata[`CTRL_SOFT_ALL]) begin
            soft_req = 4'hf;
         end
      end
   end
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (paddr == `ADDR_STATUS) begin
         rd_nxt[0] = run;
         for (int c = 0; c < `NUM_CHAN; c++) begin
            rd_nxt[4 + 4 * c +: 4] = mode_r[c];
         end
      end else if (paddr == `ADDR_XPOINT) begin
         rd_nxt[7:0] = xpoint_r;
      end else if (paddr[7:5] == `CHAN_AREA) begin
         rd_nxt = paddr[2] ? plan_p_r[paddr[4:3]] : cfg_p_r[paddr[4:3]];
      end
   end
   // one wait state; nothing answers until the load has finished
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel && penable && !pready_r && run && !hard_req) begin
         pready_r <= 1'b1;
         prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr_r <= !addr_hit(paddr);
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // initialization: one store word per cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_r <= INIT_LOAD;
         ld_cnt_r <= 3'h0;
      end else if (hard_req) begin
         init_r <= INIT_LOAD;
         ld_cnt_r <= 3'h0;
      end else begin
         case (init_r)
            INIT_LOAD: begin
               ld_cnt_r <= ld_cnt_r + 3'h1;
               if (ld_cnt_r == `LOAD_LAST) begin
                  init_r <= INIT_RUN;
               end
            end
            INIT_RUN: init_r <= INIT_RUN;
            default: init_r <= INIT_LOAD;
         endcase
      end
   end
   // the store keeps its contents across hard resets; only power-on
   // (presetn) brings back the factory image
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int w = 0; w < `NVM_WORDS; w++) begin
            nvm_r[w] <= w[0] ? `PLAN_RST : `CFG_RST;
         end
      end else if (store_req && run) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            nvm_r[2 * c] <= cfg_p_r[c];
            nvm_r[2 * c + 1] <= plan_p_r[c];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // channel configuration: pending copy for software, active copy in use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            cfg_p_r[c] <= `CFG_RST;
            plan_p_r[c] <= `PLAN_RST;
            cfg_a_r[c] <= `CFG_RST;
            plan_a_r[c] <= `PLAN_RST;
         end
      end else if (init_r == INIT_LOAD) begin
         if (ld_cnt_r[0]) begin
            plan_p_r[ld_cnt_r[2:1]] <= nvm_r[ld_cnt_r];
            plan_a_r[ld_cnt_r[2:1]] <= nvm_r[ld_cnt_r];
         end else begin
            cfg_p_r[ld_cnt_r[2:1]] <= nvm_r[ld_cnt_r];
            cfg_a_r[ld_cnt_r[2:1]] <= nvm_r[ld_cnt_r];
         end
      end else begin
         if (wr && paddr[7:5] == `CHAN_AREA && !hard_req) begin
            if (paddr[2]) begin
               plan_p_r[paddr[4:3]] <= pwdata;
            end else begin
               cfg_p_r[paddr[4:3]] <= pwdata;
            end
         end
         for (int c = 0; c < `NUM_CHAN; c++) begin
            if (soft_req[c] && !hard_req) begin
               cfg_a_r[c] <= cfg_p_r[c];
               plan_a_r[c] <= plan_p_r[c];
            end
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xpoint_r <= `XPOINT_RST;
      end else if (hard_req) begin
         xpoint_r <= `XPOINT_RST;
      end else if (wr && paddr == `ADDR_XPOINT) begin
         xpoint_r <= pwdata[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // per-channel mode machine
   always_comb begin
      logic [2:0] best;
      logic [3:0] fl;
      logic [3:0] cfgv;
      logic ok;
      best = 3'b000;
      fl = 4'h0;
      cfgv = 4'h0;
      ok = 1'b0;
      for (int c = 0; c < `NUM_CHAN; c++) begin
         best = pick_valid(valid_s2_r);
         cfgv = cfg_a_r[c][3:0];
         // auto stays on a still-valid input rather than reverting
         if (!cfgv[`CFG_AUTO]) begin
            sel_nxt[c] = cfgv[`CFG_SEL_LSB +: 2];
         end else if (valid_s2_r[sel_r[c]]) begin
            sel_nxt[c] = sel_r[c];
         end else begin
            sel_nxt[c] = best[1:0];
         end
         ok = valid_s2_r[sel_nxt[c]];
         case (mode_r[c])
            MODE_FREERUN: mode_nxt[c] = ok ? MODE_ACQUIRE : MODE_FREERUN;
            MODE_ACQUIRE: begin
               if (!ok) begin
                  mode_nxt[c] = MODE_FREERUN;
               end else if (lock_s2_r[c]) begin
                  mode_nxt[c] = MODE_LOCKED;
               end else begin
                  mode_nxt[c] = MODE_ACQUIRE;
               end
            end
            MODE_LOCKED: begin
               if (ok) begin
                  mode_nxt[c] = (sel_nxt[c] == sel_r[c]) ? MODE_LOCKED
                                                          : MODE_ACQUIRE;
               end else begin
                  mode_nxt[c] = MODE_HOLDOVER;
               end
            end
            MODE_HOLDOVER: mode_nxt[c] = ok ? MODE_ACQUIRE : MODE_HOLDOVER;
            default: mode_nxt[c] = MODE_FREERUN;
         endcase
         fl = cfg_a_r[c][`CFG_FLBW_LSB +: 4];
         if (fl < `FLBW_MIN_CODE) begin
            fl = `FLBW_MIN_CODE;
         end
         if (mode_nxt[c] == MODE_ACQUIRE && cfg_a_r[c][`CFG_FL_EN]) begin
            bw_nxt[c] = fl;
         end else begin
            bw_nxt[c] = cfg_a_r[c][`CFG_LBW_LSB +: 4];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            mode_r[c] <= MODE_FREERUN;
            sel_r[c] <= 2'b00;
            bw_r[c] <= `LBW_MIN_CODE;
         end
      end else begin
         for (int c = 0; c < `NUM_CHAN; c++) begin
            if (!run || hard_req || soft_req[c]) begin
               mode_r[c] <= MODE_FREERUN;
               sel_r[c] <= cfg_a_r[c][`CFG_SEL_LSB +: 2];
               bw_r[c] <= cfg_a_r[c][`CFG_LBW_LSB +: 4];
            end else begin
               mode_r[c] <= mode_nxt[c];
               sel_r[c] <= sel_nxt[c];
               bw_r[c] <= bw_nxt[c];
            end
         end
      end
   end
   // clocks only leave the device once the load is through
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_en_r <= 4'h0;
      end else begin
         out_en_r <= (run && !hard_req) ? 4'hf : 4'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   // one-hot run bit of the init state register
   assign init_done = init_r[1];
   assign clk_out_enable = out_en_r;
   assign clk_out_chan = xpoint_r;
   always_comb begin
      chan_mode = 16'h0000;
      chan_input = 8'h00;
      chan_bw = 16'h0000;
      chan_plan = 128'h0;
      for (int c = 0; c < `NUM_CHAN; c++) begin
         chan_mode[4 * c +: 4] = mode_r[c];
         chan_input[2 * c +: 2] = sel_r[c];
         chan_bw[4 * c +: 4] = bw_r[c];
         chan_plan[32 * c +: 32] = plan_a_r[c];
      end
   end

endmodule : pll_mode_reset_control
`default_nettype wire

/* verif/pll_mode_reset_control_assertions.sv */
// checker on the top ports of the pll mode and reset controller
// assumes one pclk domain, bound onto pll_mode_reset_control
`timescale 1ns/1ps
`default_nettype none
module pll_mode_reset_control_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic init_done,
   input wire logic [3:0] clk_out_enable,
   input wire logic [15:0] chan_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   property p_ready_after_init;
      pready |-> init_done;
   endproperty
   a_ready_after_init: assert property (p_ready_after_init)
      else $error("bus answered during load");
   property p_out_off;
      !init_done [*2] |-> clk_out_enable == 4'h0;
   endproperty
   a_out_off: assert property (p_out_off)
      else $error("output clocks on during load");
   property p_out_on;
      $rose(init_done) |=> clk_out_enable == 4'hf;
   endproperty
   a_out_on: assert property (p_out_on)
      else $error("output clocks not on after load");
   property p_one_mode;
      $onehot(chan_mode[3:0]) && $onehot(chan_mode[7:4]) &&
      $onehot(chan_mode[11:8]) && $onehot(chan_mode[15:12]);
   endproperty
   a_one_mode: assert property (p_one_mode)
      else $error("channel mode not one-hot");
   property p_freerun;
      $rose(init_done) |-> chan_mode == 16'h1111;
   endproperty
   a_freerun: assert property (p_freerun)
      else $error("channels not free-run at end of load");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");
   property p_answer;
      init_done && psel && $rose(penable) |=> pready;
   endproperty
   a_answer: assert property (p_answer)
      else $error("no answer one cycle into access");
   c_init: cover property ($rose(init_done));
   c_err: cover property (pslverr);
   c_hold: cover property (chan_mode == 16'h8888);
endmodule : pll_mode_reset_control_assertions
`default_nettype wire

/* verif/apb_host_model.sv */
// host controller on the apb side of the pll controller
// assumes a single pclk; xfer is called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   ////////////////////////////////////////
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // stalls while the device loads; a hang is left to the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : apb_host_model
`default_nettype wire

/* verif/pll_mode_reset_control_tb_top.sv */
// self-checking bench for the pll mode and reset controller
// assumes apb_host_model and the checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_defs.svh"
module pll_mode_reset_control_tb_top;
   logic pclk = 1'b0;
   logic presetn, reset_pin_active_low, psel, penable, pwrite, pready;
   logic pslverr, init_done, erv;
   logic [3:0] in_valid, lock_done, clk_out_enable;
   logic [7:0] paddr, clk_out_chan, chan_input, xp;
   logic [15:0] chan_mode, chan_bw;
   logic [31:0] pwdata, prdata, rdv;
   logic [127:0] chan_plan;
   logic [31:0] exp_plan [4];
   logic [31:0] sto_plan [4];
   int mismatches = 0, samples_checked = 0, seed = 40949;
   always #25 pclk = ~pclk;
   apb_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   pll_mode_reset_control uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_active_low(reset_pin_active_low),
      .in_valid(in_valid), .lock_done(lock_done), .init_done(init_done),
      .clk_out_enable(clk_out_enable), .clk_out_chan(clk_out_chan),
      .chan_mode(chan_mode), .chan_input(chan_input), .chan_bw(chan_bw),
      .chan_plan(chan_plan));
   ////////////////////////////////////////
   function automatic logic [7:0] ca(input int c);
      return 8'(32'h20 + 8 * c);
   endfunction : ca
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rdv, erv);
   endtask : wr
   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rdv, erv);
      chk(nm, rdv, exp);
   endtask : rchk
   task automatic wait_mode(input logic [15:0] m);
      int n;
      n = 0;
      while (chan_mode !== m && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk("chan_mode", chan_mode, m);
   endtask : wait_mode
   task automatic wait_init();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      chk("init_done", init_done, 32'h1);
   endtask : wait_init
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      reset_pin_active_low = 1'b1;
      in_valid = 4'h0;
      lock_done = 4'h0;
      repeat (20) @(posedge pclk);
      chk("clk_out_enable", clk_out_enable, 32'h0);
      presetn <= 1'b1;
      wait_init();
      chk("chan_mode", chan_mode, 32'h1111);
      rchk("status", `ADDR_STATUS, 32'h0001_1111);
      chk("clk_out_enable", clk_out_enable, 32'hf);
      for (int c = 0; c < 4; c++) begin
         rchk("cfg", ca(c), `CFG_RST);
         rchk("plan", ca(c) + 8'h4, `PLAN_RST);
      end
      host.xfer(1'b0, 8'h0c, 32'h0, rdv, erv);
      chk("pslverr", erv, 32'h1);
      $display("test init done");
      for (int c = 0; c < 4; c++) begin
         exp_plan[c] = $random(seed);
         wr(ca(c) + 8'h4, exp_plan[c]);
         rchk("plan", ca(c) + 8'h4, exp_plan[c]);
      end
      xp = 8'($random(seed));
      wr(`ADDR_XPOINT, {24'h0, xp});
      rchk("xpoint", `ADDR_XPOINT, {24'h0, xp});
      chk("clk_out_chan", clk_out_chan, xp);
      wr(`ADDR_CTRL, 32'h20);
      @(posedge pclk);
      #1;
      chk("plan1", chan_plan[63:32], exp_plan[1]);
      chk("plan0", chan_plan[31:0], `PLAN_RST);
      wr(`ADDR_CTRL, 32'h2);
      @(posedge pclk);
      #1;
      chk("plan3", chan_plan[127:96], exp_plan[3]);
      $display("test plan done");
      // ch0,2 fastlock on; ch2 fastlock code below the floor
      wr(ca(0), 32'h0c38);
      wr(ca(1), 32'h0cf0);
      wr(ca(2), 32'h0238);
      wr(ca(3), 32'h0c00);
      wr(`ADDR_CTRL, 32'h2);
      in_valid <= 4'h1;
      wait_mode(16'h2222);
      chk("chan_bw", chan_bw, 32'h08fc);
      chk("chan_input", chan_input, 32'h0);
      lock_done <= 4'hf;
      wait_mode(16'h4444);
      chk("chan_bw", chan_bw, 32'h03f3);
      in_valid <= 4'h0;
      lock_done <= 4'h0;
      wait_mode(16'h8888);
      in_valid <= 4'h1;
      wait_mode(16'h2222);
      $display("test modes done");
      in_valid <= 4'h0;
      wr(`ADDR_CTRL, 32'h4);
      sto_plan = exp_plan;
      wr(ca(0) + 8'h4, ~exp_plan[0]);
      wr(`ADDR_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      chk("clk_out_enable", clk_out_enable, 32'h0);
      wait_init();
      rchk("plan0", ca(0) + 8'h4, sto_plan[0]);
      chk("active0", chan_plan[31:0], sto_plan[0]);
      rchk("xpoint", `ADDR_XPOINT, 32'h0);
      chk("chan_mode", chan_mode, 32'h1111);
      wr(ca(1) + 8'h4, ~sto_plan[1]);
      reset_pin_active_low <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("init_done", init_done, 32'h0);
      reset_pin_active_low <= 1'b1;
      wait_init();
      rchk("plan1", ca(1) + 8'h4, sto_plan[1]);
      $display("test hard reset done");
      // ch0 back to auto select with only input 2 valid
      wr(ca(0), 32'h0c84);
      wr(`ADDR_CTRL, 32'h10);
      in_valid <= 4'h4;
      wait_mode(16'h1112);
      chk("chan_input", chan_input, 32'h02);
      chk("chan_bw", chan_bw, 32'h03f8);
      $display("test auto select done");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      final_report();
   end
endmodule : pll_mode_reset_control_tb_top
bind pll_mode_reset_control pll_mode_reset_control_assertions chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .init_done(init_done),
   .clk_out_enable(clk_out_enable), .chan_mode(chan_mode));
`default_nettype wire
